// ==== common/cmwc_pkg.sv ====
package cmwc_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // The four pin-free mode timers; the longer ones are defaults for top-level parameters.
  localparam int SLEEP_ENTRY_DELAY_NS = 20000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FILTER_TIME_NS = 1000;
  localparam int BUS_FILTER_CYC = (BUS_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W = $clog2(BUS_FILTER_CYC + 2);
  localparam int PATTERN_WINDOW_TIME_US = 1000;
  localparam int PATTERN_WINDOW_CYC = (PATTERN_WINDOW_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int STANDBY_EXPIRY_TIME_MS = 1000;
  localparam int STANDBY_EXPIRY_CYC = (STANDBY_EXPIRY_TIME_MS * 1000000) / CLK_PERIOD_NS;

  localparam int APB_ADDR_W = 8;
  localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [APB_ADDR_W-1:0] WAKE_SRC_OFFSET = 8'h08;

  localparam int CTRL_LOCAL_EN_BIT = 0;
  localparam int CTRL_REMOTE_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_WAKE_REQ_BIT = 4;
  localparam int STAT_PWR_UP_BIT = 5;
  localparam int STAT_ARMED_BIT = 6;
  localparam int STAT_SWE_CAUSE_BIT = 7;
  localparam int STAT_WUP_LSB = 8;

  localparam int SRC_LOCAL_BIT = 0;
  localparam int SRC_REMOTE_BIT = 1;

  typedef enum logic [2:0] {
    CMWC_STANDBY = 3'h0,
    CMWC_GOTOSLEEP = 3'h1,
    CMWC_SLEEP = 3'h3,
    CMWC_NORMAL = 3'h2,
    CMWC_SILENT = 3'h6
  } cmwc_mode_type;

  typedef enum logic [1:0] {
    CMWC_WUP_IDLE = 2'h0,
    CMWC_WUP_DOM1 = 2'h1,
    CMWC_WUP_REC = 2'h3,
    CMWC_WUP_BLOCK = 2'h2
  } cmwc_wup_type;

endpackage

// ==== dv/cmwc_bus_model.sv ====
`timescale 1ns/1ps
module cmwc_bus_model (
  input wire logic pclk,
  input wire logic driver_en,
  input wire logic bus_drive_dominant,
  output logic bus_dominant
);
  logic remote_dom;
  initial remote_dom = 1'b0;
  // A dominant from any node overrides recessive, so our own drive echoes back.
  assign bus_dominant = remote_dom | (driver_en & bus_drive_dominant);
  task automatic hold_state(input logic dom, input int cycles);
    remote_dom <= dom;
    repeat (cycles) @(posedge pclk);
  endtask
  task automatic send_pattern(input int cycles);
    hold_state(1'b1, cycles);
    hold_state(1'b0, cycles);
    hold_state(1'b1, cycles);
    remote_dom <= 1'b0;
  endtask
endmodule

// ==== dv/cmwc_mode_wake_control_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module cmwc_mode_wake_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic standby_ctl_n = 1'b0;
  logic mode_sel = 1'b0;
  logic txd = 1'b1;
  logic bus_dominant;
  logic local_wake_event = 1'b0;
  logic local_failure = 1'b0;
  logic io_rail_good_level = 1'b1;
  logic rxd, bus_drive_dominant, driver_en, receiver_en, monitor_en;
  logic supply_gate_out, supply_gate_oe, fault_indicator_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic rerr;
  always #5 pclk = ~pclk;
  cmwc_mode_wake_control #(.STANDBY_EXPIRY_CYC(200), .PATTERN_WINDOW_CYC(1000)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_ctl_n(standby_ctl_n), .mode_sel(mode_sel), .txd(txd), .bus_dominant(bus_dominant),
    .local_wake_event(local_wake_event), .local_failure(local_failure),
    .io_rail_good_level(io_rail_good_level), .rxd(rxd), .bus_drive_dominant(bus_drive_dominant),
    .driver_en(driver_en), .receiver_en(receiver_en), .monitor_en(monitor_en),
    .supply_gate_out(supply_gate_out), .supply_gate_oe(supply_gate_oe),
    .fault_indicator_n(fault_indicator_n));
  cmwc_bus_model bus (.pclk(pclk), .driver_en(driver_en), .bus_drive_dominant(bus_drive_dominant),
    .bus_dominant(bus_dominant));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Entered just after a rising edge; a spare edge follows so psel is never reassigned at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    `CHK(what, exp, rdata & mask)
  endtask
  task automatic pins(input logic stb_n, input logic sel, input int n);
    standby_ctl_n <= stb_n;
    mode_sel <= sel;
    cyc(n);
  endtask
  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(1);
    rdc(cmwc_pkg::CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000003, "ctrl reset");
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h000000BF, 32'h00000020, "status reset");
    rdc(8'h0C, 32'hFFFFFFFF, 32'h00000000, "unmapped data");
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("standby driver", 1'b0, driver_en)
    $display("test reset done");
    pins(1'b1, 1'b1, 4);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000037, 32'h00000002, "normal flags");
    `CHK("normal driver", 1'b1, driver_en)
    txd <= 1'b0;
    cyc(6);
    `CHK("tx dominant", 1'b1, bus_drive_dominant)
    `CHK("rx dominant", 1'b0, rxd)
    txd <= 1'b1;
    cyc(6);
    `CHK("rx recessive", 1'b1, rxd)
    $display("test normal done");
    local_failure <= 1'b1;
    pins(1'b1, 1'b0, 4);
    `CHK("silent driver", 1'b0, driver_en)
    `CHK("silent receiver", 1'b1, receiver_en)
    `CHK("silent fault", 1'b0, fault_indicator_n)
    bus.hold_state(1'b1, 6);
    `CHK("silent rx", 1'b0, rxd)
    bus.hold_state(1'b0, 2);
    local_failure <= 1'b0;
    $display("test silent done");
    pins(1'b0, 1'b1, cmwc_pkg::SLEEP_ENTRY_CYC + 10);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000003, "sleep mode");
    `CHK("sleep gate oe", 1'b0, supply_gate_oe)
    `CHK("sleep gate out", 1'b0, supply_gate_out)
    `CHK("sleep driver", 1'b0, driver_en)
    `CHK("sleep monitor", 1'b1, monitor_en)
    bus.send_pattern(120);
    cyc(6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000017, 32'h00000010, "remote wake");
    `CHK("wake rx", 1'b0, rxd)
    `CHK("wake gate oe", 1'b1, supply_gate_oe)
    pins(1'b1, 1'b1, 4);
    `CHK("wake source fault", 1'b0, fault_indicator_n)
    rdc(cmwc_pkg::WAKE_SRC_OFFSET, 32'h00000003, 32'h00000002, "wake source");
    apb(1'b1, cmwc_pkg::WAKE_SRC_OFFSET, 32'h00000003);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000017, 32'h00000002, "wake cleared");
    $display("test wake done");
    pins(1'b0, 1'b0, 230);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000087, 32'h00000083, "expiry sleep");
    io_rail_good_level <= 1'b0;
    pins(1'b1, 1'b0, 4);
    pins(1'b1, 1'b1, 6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000003, "rail low exit");
    io_rail_good_level <= 1'b1;
    pins(1'b1, 1'b0, 6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000006, "expiry to silent");
    pins(1'b1, 1'b1, 6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000002, "silent to normal");
    $display("test expiry done");
    pins(1'b0, 1'b0, 20);
    pins(1'b1, 1'b0, 200);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h000000C7, 32'h00000083, "silent expiry");
    pins(1'b1, 1'b1, 6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000047, 32'h00000003, "unarmed exit");
    pins(1'b0, 1'b0, 4);
    pins(1'b1, 1'b0, 4);
    pins(1'b1, 1'b1, 6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000002, "armed exit");
    $display("test arming done");
    pins(1'b0, 1'b0, 2);
    bus.hold_state(1'b1, 120);
    bus.hold_state(1'b0, 1100);
    bus.hold_state(1'b1, 120);
    bus.hold_state(1'b0, 1100);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000017, 32'h00000003, "window timeout");
    bus.hold_state(1'b1, 1150);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000307, 32'h00000203, "dominant timeout");
    bus.hold_state(1'b0, 120);
    bus.send_pattern(120);
    cyc(6);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000017, 32'h00000010, "wake after timeout");
    $display("test window done");
    pins(1'b0, 1'b1, 10);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000007, 32'h00000000, "pending holds standby");
    pins(1'b1, 1'b1, 4);
    pins(1'b0, 1'b1, cmwc_pkg::SLEEP_ENTRY_CYC + 10);
    local_wake_event <= 1'b1;
    cyc(1);
    local_wake_event <= 1'b0;
    cyc(4);
    rdc(cmwc_pkg::STATUS_OFFSET, 32'h00000017, 32'h00000010, "local wake");
    rdc(cmwc_pkg::WAKE_SRC_OFFSET, 32'h00000001, 32'h00000001, "local source");
    $display("test local done");
    end_of_test();
  end
endmodule

// ==== hdl/cmwc_mode_wake_control.sv ====
`timescale 1ns/1ps
// Function
// R1 - Go-to-sleep expires into sleep, gate floats
// R2 - Normal mode drives transmit, mirrors bus
// R3 - Normal entry clears wake and power-up flags; a wake_hit in the entry cycle sets the wake flag instead
// R4 - Normal entry stops and zeroes expiry timer
// R5 - Silent keeps driver off, receiver active
// R6 - Silent shows power-up, local failure on fault
// R7 - Silent from standby keeps expiry timer running
// R8 - Standby disables driver, pending wake pulls receive
// R9 - Normal reports wake source on fault output
// R10 - Standby expiry timer forces sleep when late
// R11 - Pending wake holds standby instead of sleep
// R12 - Sleep leaves only low-power monitors active
// R13 - Sleep exits on pattern, local wake, rising
// R14 - Expiry sleep exits on mode-select edge, standby high
// R15 - Host toggles mode-select with standby low first
// R16 - Pin exits ignored without good logic rail
// R17 - Pattern dominant, recessive, dominant; traffic tolerated
// R18 - Pattern pulls receive low once rail good
// R19 - Filtered means held beyond filter time
// R20 - Filter time fits one slow bit
// R21 - Pattern must finish inside window else reset
// R22 - Timeout on dominant needs filtered recessive first
// R23 - Two pins select the operating mode
// R24 - Standby rise exits go-to-sleep or undervoltage sleep
// R25 - Pins sampled, timers count the clock
module cmwc_mode_wake_control #(
  parameter int STANDBY_EXPIRY_CYC = cmwc_pkg::STANDBY_EXPIRY_CYC,
  parameter int PATTERN_WINDOW_CYC = cmwc_pkg::PATTERN_WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmwc_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby_ctl_n,
  input wire logic mode_sel,
  input wire logic txd,
  input wire logic bus_dominant,
  input wire logic local_wake_event,
  input wire logic local_failure,
  input wire logic io_rail_good_level,
  output logic rxd,
  output logic bus_drive_dominant,
  output logic driver_en,
  output logic receiver_en,
  output logic monitor_en,
  output logic supply_gate_out,
  output logic supply_gate_oe,
  output logic fault_indicator_n
);

  localparam int SLEEP_LAST = cmwc_pkg::SLEEP_ENTRY_CYC - 1;
  function automatic cmwc_pkg::cmwc_mode_type pin_mode(input logic stb_n, input logic sel);
    if (stb_n) begin
      pin_mode = sel ? cmwc_pkg::CMWC_NORMAL : cmwc_pkg::CMWC_SILENT;
    end else begin
      pin_mode = sel ? cmwc_pkg::CMWC_GOTOSLEEP : cmwc_pkg::CMWC_STANDBY;
    end
  endfunction
  function automatic logic low_power(input cmwc_pkg::cmwc_mode_type m);
    low_power = (m == cmwc_pkg::CMWC_STANDBY) || (m == cmwc_pkg::CMWC_GOTOSLEEP) || (m == cmwc_pkg::CMWC_SLEEP);
  endfunction
  function automatic logic addr_known(input logic [cmwc_pkg::APB_ADDR_W-1:0] a);
    addr_known = (a == cmwc_pkg::CTRL_OFFSET) || (a == cmwc_pkg::STATUS_OFFSET) || (a == cmwc_pkg::WAKE_SRC_OFFSET);
  endfunction

  cmwc_pkg::cmwc_mode_type mode_reg, mode_next;
  cmwc_pkg::cmwc_wup_type wup_reg;
  logic stb_prev_reg, en_prev_reg, bus_prev_reg, wup_detect_reg, swe_active_reg, swe_cause_reg, armed_reg;
  logic wake_request_flag_reg, power_up_flag_reg, pready_reg, pslverr_reg, rxd_reg, bus_drive_dominant_reg;
  logic driver_en_reg, receiver_en_reg, monitor_en_reg, supply_gate_out_reg, supply_gate_oe_reg;
  logic fault_indicator_n_reg;
  logic [31:0] gts_cnt_reg, swe_cnt_reg, win_cnt_reg, prdata_reg, status_word;
  logic [1:0] wake_src_reg, ctrl_reg;
  logic [cmwc_pkg::FILT_CNT_W-1:0] filt_cnt_reg;
  logic stb_rise, en_rise, en_fall, swe_expired, filt_hit, local_hit, remote_hit, wake_hit, normal_entry;
  logic apb_write, src_clr_local, src_clr_remote;

  assign {prdata, pready, pslverr} = {prdata_reg, pready_reg, pslverr_reg};
  assign {rxd, bus_drive_dominant, driver_en} = {rxd_reg, bus_drive_dominant_reg, driver_en_reg};
  assign {receiver_en, monitor_en, fault_indicator_n} = {receiver_en_reg, monitor_en_reg, fault_indicator_n_reg};
  assign {supply_gate_out, supply_gate_oe} = {supply_gate_out_reg, supply_gate_oe_reg};
  // R25 pin edges
  assign stb_rise = standby_ctl_n && !stb_prev_reg;
  assign en_rise = mode_sel && !en_prev_reg;
  assign en_fall = !mode_sel && en_prev_reg;
  assign swe_expired = swe_active_reg && (swe_cnt_reg == 32'(STANDBY_EXPIRY_CYC - 1));
  assign local_hit = ctrl_reg[cmwc_pkg::CTRL_LOCAL_EN_BIT] && local_wake_event && low_power(mode_reg);
  assign remote_hit = ctrl_reg[cmwc_pkg::CTRL_REMOTE_EN_BIT] && wup_detect_reg && low_power(mode_reg);
  assign wake_hit = local_hit || remote_hit;
  assign normal_entry = (mode_next == cmwc_pkg::CMWC_NORMAL) && (mode_reg != cmwc_pkg::CMWC_NORMAL);

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      cmwc_pkg::CMWC_NORMAL, cmwc_pkg::CMWC_SILENT, cmwc_pkg::CMWC_STANDBY, cmwc_pkg::CMWC_GOTOSLEEP: begin
        // R23 pin decode
        mode_next = pin_mode(standby_ctl_n, mode_sel);
        // R11 pending wake
        if (mode_next == cmwc_pkg::CMWC_GOTOSLEEP && (wake_request_flag_reg || wake_hit)) begin
          mode_next = cmwc_pkg::CMWC_STANDBY;
        end else if (mode_reg == cmwc_pkg::CMWC_GOTOSLEEP && mode_next == cmwc_pkg::CMWC_GOTOSLEEP &&
                     gts_cnt_reg == 32'(SLEEP_LAST)) begin
          // R1 sleep entry
          mode_next = cmwc_pkg::CMWC_SLEEP;
        end
        // R10 expiry forces sleep
        if (swe_expired && mode_next != cmwc_pkg::CMWC_NORMAL && !wake_request_flag_reg && !wake_hit) begin
          mode_next = cmwc_pkg::CMWC_SLEEP;
        end
      end
      cmwc_pkg::CMWC_SLEEP: begin
        // R13 sleep exits
        if (wake_hit) begin
          mode_next = cmwc_pkg::CMWC_STANDBY;
        end else if (io_rail_good_level) begin
          // R16 rail check
          if (!swe_cause_reg && stb_rise) begin
            // R24 standby rise exit
            mode_next = mode_sel ? cmwc_pkg::CMWC_NORMAL : cmwc_pkg::CMWC_SILENT;
          end else if (swe_cause_reg && armed_reg && standby_ctl_n && (en_rise || en_fall)) begin
            // R14 mode-select edge exit
            mode_next = en_rise ? cmwc_pkg::CMWC_NORMAL : cmwc_pkg::CMWC_SILENT;
          end
        end
      end
      default: begin
        mode_next = cmwc_pkg::CMWC_STANDBY;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= cmwc_pkg::CMWC_STANDBY;
      stb_prev_reg <= 1'h0;
      en_prev_reg <= 1'h0;
    end else begin
      mode_reg <= mode_next;
      stb_prev_reg <= standby_ctl_n;
      en_prev_reg <= mode_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gts_cnt_reg <= 32'h0;
    end else if (mode_reg == cmwc_pkg::CMWC_GOTOSLEEP && mode_next == cmwc_pkg::CMWC_GOTOSLEEP) begin
      gts_cnt_reg <= gts_cnt_reg + 32'h1;
    end else begin
      gts_cnt_reg <= 32'h0;
    end
  end

  // The expiry timer saturates so a wake held pending keeps standby rather than wrapping.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swe_active_reg <= 1'h0;
      swe_cnt_reg <= 32'h0;
    end else if (mode_next == cmwc_pkg::CMWC_STANDBY ||
                 (mode_next == cmwc_pkg::CMWC_SILENT && swe_active_reg)) begin
      // R7 silent keeps timer
      swe_active_reg <= 1'h1;
      if (!swe_expired) begin
        swe_cnt_reg <= swe_cnt_reg + 32'h1;
      end
    end else begin
      // R4 timer halt reset
      swe_active_reg <= 1'h0;
      swe_cnt_reg <= 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swe_cause_reg <= 1'h0;
      armed_reg <= 1'h1;
    end else if (mode_next == cmwc_pkg::CMWC_SLEEP && mode_reg != cmwc_pkg::CMWC_SLEEP) begin
      swe_cause_reg <= swe_expired;
      armed_reg <= !standby_ctl_n;
    end else if (mode_reg == cmwc_pkg::CMWC_SLEEP && !standby_ctl_n && (en_rise || en_fall)) begin
      // R15 arming toggle
      armed_reg <= 1'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_flag_reg <= 1'h0;
      power_up_flag_reg <= 1'h1;
    end else begin
      if (wake_hit) begin
        wake_request_flag_reg <= 1'h1;
      end else if (normal_entry) begin
        // R3 flag clear
        wake_request_flag_reg <= 1'h0;
      end
      if (normal_entry) begin
        power_up_flag_reg <= 1'h0;
      end
    end
  end

  assign apb_write = psel && penable && pready_reg && pwrite;
  assign src_clr_local = apb_write && (paddr == cmwc_pkg::WAKE_SRC_OFFSET) && pwdata[cmwc_pkg::SRC_LOCAL_BIT];
  assign src_clr_remote = apb_write && (paddr == cmwc_pkg::WAKE_SRC_OFFSET) && pwdata[cmwc_pkg::SRC_REMOTE_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_src_reg <= 2'h0;
    end else begin
      wake_src_reg[cmwc_pkg::SRC_LOCAL_BIT] <= local_hit || (wake_src_reg[cmwc_pkg::SRC_LOCAL_BIT] && !src_clr_local);
      wake_src_reg[cmwc_pkg::SRC_REMOTE_BIT] <= remote_hit ||
                                                (wake_src_reg[cmwc_pkg::SRC_REMOTE_BIT] && !src_clr_remote);
    end
  end

  // R19 R20 filter count
  assign filt_hit = (bus_dominant == bus_prev_reg) && (filt_cnt_reg == cmwc_pkg::FILT_CNT_W'(cmwc_pkg::BUS_FILTER_CYC));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_prev_reg <= 1'h0;
      filt_cnt_reg <= '0;
    end else begin
      bus_prev_reg <= bus_dominant;
      if (bus_dominant != bus_prev_reg || !low_power(mode_reg)) begin
        filt_cnt_reg <= '0;
      end else if (filt_cnt_reg <= cmwc_pkg::FILT_CNT_W'(cmwc_pkg::BUS_FILTER_CYC)) begin
        filt_cnt_reg <= filt_cnt_reg + cmwc_pkg::FILT_CNT_W'(1);
      end
    end
  end

  // R17 pattern sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wup_reg <= cmwc_pkg::CMWC_WUP_IDLE;
      win_cnt_reg <= 32'h0;
      wup_detect_reg <= 1'h0;
    end else begin
      wup_detect_reg <= 1'h0;
      if (!low_power(mode_reg)) begin
        wup_reg <= cmwc_pkg::CMWC_WUP_IDLE;
        win_cnt_reg <= 32'h0;
      end else begin
        unique case (wup_reg)
          cmwc_pkg::CMWC_WUP_IDLE: begin
            win_cnt_reg <= 32'h0;
            if (filt_hit && bus_dominant) begin
              wup_reg <= cmwc_pkg::CMWC_WUP_DOM1;
            end
          end
          cmwc_pkg::CMWC_WUP_DOM1, cmwc_pkg::CMWC_WUP_REC: begin
            win_cnt_reg <= win_cnt_reg + 32'h1;
            if (wup_reg == cmwc_pkg::CMWC_WUP_REC && filt_hit && bus_dominant) begin
              wup_reg <= cmwc_pkg::CMWC_WUP_IDLE;
              wup_detect_reg <= 1'h1;
              win_cnt_reg <= 32'h0;
            end else if (win_cnt_reg == 32'(PATTERN_WINDOW_CYC - 1)) begin
              // R21 window timeout
              // R22 dominant timeout blocks
              wup_reg <= bus_dominant ? cmwc_pkg::CMWC_WUP_BLOCK : cmwc_pkg::CMWC_WUP_IDLE;
              win_cnt_reg <= 32'h0;
            end else if (wup_reg == cmwc_pkg::CMWC_WUP_DOM1 && filt_hit && !bus_dominant) begin
              wup_reg <= cmwc_pkg::CMWC_WUP_REC;
            end
          end
          cmwc_pkg::CMWC_WUP_BLOCK: begin
            win_cnt_reg <= 32'h0;
            if (filt_hit && !bus_dominant) begin
              wup_reg <= cmwc_pkg::CMWC_WUP_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_reg <= 1'h1;
      bus_drive_dominant_reg <= 1'h0;
      driver_en_reg <= 1'h0;
      receiver_en_reg <= 1'h0;
      monitor_en_reg <= 1'h1;
      supply_gate_out_reg <= 1'h1;
      supply_gate_oe_reg <= 1'h1;
      fault_indicator_n_reg <= 1'h1;
    end else begin
      // R2 normal drive
      driver_en_reg <= (mode_reg == cmwc_pkg::CMWC_NORMAL);
      bus_drive_dominant_reg <= (mode_reg == cmwc_pkg::CMWC_NORMAL) && !txd;
      // R5 silent receive
      receiver_en_reg <= (mode_reg == cmwc_pkg::CMWC_NORMAL) || (mode_reg == cmwc_pkg::CMWC_SILENT);
      // R12 sleep monitors only
      monitor_en_reg <= low_power(mode_reg);
      supply_gate_out_reg <= (mode_reg != cmwc_pkg::CMWC_SLEEP);
      supply_gate_oe_reg <= (mode_reg != cmwc_pkg::CMWC_SLEEP);
      if (low_power(mode_reg)) begin
        // R8 wake on receive
        // R18 rail gated
        rxd_reg <= !(wake_request_flag_reg && io_rail_good_level);
      end else begin
        rxd_reg <= !bus_dominant;
      end
      if (mode_reg == cmwc_pkg::CMWC_SILENT) begin
        // R6 silent fault
        fault_indicator_n_reg <= !(power_up_flag_reg || local_failure);
      end else if (mode_reg == cmwc_pkg::CMWC_NORMAL) begin
        // R9 wake source
        fault_indicator_n_reg <= !(|wake_src_reg);
      end else begin
        fault_indicator_n_reg <= 1'h1;
      end
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[cmwc_pkg::STAT_MODE_LSB +: 3] = mode_reg;
    status_word[cmwc_pkg::STAT_WAKE_REQ_BIT] = wake_request_flag_reg;
    status_word[cmwc_pkg::STAT_PWR_UP_BIT] = power_up_flag_reg;
    status_word[cmwc_pkg::STAT_ARMED_BIT] = armed_reg;
    status_word[cmwc_pkg::STAT_SWE_CAUSE_BIT] = swe_cause_reg;
    status_word[cmwc_pkg::STAT_WUP_LSB +: 2] = wup_reg;
  end

  // Read data is captured in the setup cycle, so every access completes with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      pready_reg <= psel && !penable;
      pslverr_reg <= psel && !penable && !addr_known(paddr);
      prdata_reg <= 32'h0;
      if (psel && !penable && !pwrite) begin
        if (paddr == cmwc_pkg::CTRL_OFFSET) begin
          prdata_reg <= {30'h0, ctrl_reg};
        end else if (paddr == cmwc_pkg::STATUS_OFFSET) begin
          prdata_reg <= status_word;
        end else if (paddr == cmwc_pkg::WAKE_SRC_OFFSET) begin
          prdata_reg <= {30'h0, wake_src_reg};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= cmwc_pkg::CTRL_RESET;
    end else if (apb_write && paddr == cmwc_pkg::CTRL_OFFSET) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NORMAL_CLEARS_FLAGS: assert property ( // R3
    (mode_reg == cmwc_pkg::CMWC_NORMAL && $past(mode_reg) != cmwc_pkg::CMWC_NORMAL)
      |-> (!wake_request_flag_reg && !power_up_flag_reg))
    else $error("Flags not cleared on normal entry.");
  AST_NORMAL_TIMER_ZERO: assert property ( // R4
    (mode_reg == cmwc_pkg::CMWC_NORMAL) |-> (swe_cnt_reg == 32'h0 && !swe_active_reg))
    else $error("Expiry timer running in normal.");
  AST_SLEEP_ENTRY_DELAY: assert property ( // R1
    (mode_reg == cmwc_pkg::CMWC_SLEEP && $past(mode_reg) == cmwc_pkg::CMWC_GOTOSLEEP)
      |-> ($past(gts_cnt_reg) == 32'(SLEEP_LAST)))
    else $error("Sleep entered before the entry delay.");
  AST_SLEEP_GATE_FLOAT: assert property ( // R12
    (mode_reg == cmwc_pkg::CMWC_SLEEP) |=> (!supply_gate_oe_reg && !driver_en_reg && !receiver_en_reg && monitor_en_reg))
    else $error("Sleep outputs wrong.");
  AST_NORMAL_DRIVE: assert property ( // R2
    (mode_reg == cmwc_pkg::CMWC_NORMAL) |=> (bus_drive_dominant_reg == !$past(txd) && rxd_reg == !$past(bus_dominant)))
    else $error("Normal mode does not follow transmit or bus.");
  AST_SILENT_NO_DRIVE: assert property ( // R5
    (mode_reg == cmwc_pkg::CMWC_SILENT) |=> (!driver_en_reg && !bus_drive_dominant_reg && receiver_en_reg))
    else $error("Silent mode drives the bus.");
  AST_SILENT_FAULT: assert property ( // R6
    (mode_reg == cmwc_pkg::CMWC_SILENT) |=> (fault_indicator_n_reg == !($past(power_up_flag_reg) || $past(local_failure))))
    else $error("Silent fault output wrong.");
  AST_STANDBY_WAKE_RXD: assert property ( // R8
    (mode_reg == cmwc_pkg::CMWC_STANDBY && wake_request_flag_reg && io_rail_good_level) |=> !rxd_reg)
    else $error("Pending wake not shown on receive.");
  AST_RAIL_BLOCKS_PIN_EXIT: assert property ( // R16
    (mode_reg == cmwc_pkg::CMWC_SLEEP && !io_rail_good_level && !wake_hit) |=> (mode_reg == cmwc_pkg::CMWC_SLEEP))
    else $error("Sleep left without good rail.");
  AST_WINDOW_BOUND: assert property ( // R21
    (win_cnt_reg == 32'(PATTERN_WINDOW_CYC - 1)) |=> (win_cnt_reg == 32'h0))
    else $error("Pattern window overran.");

  COV_ENTER_SLEEP: cover property (mode_reg == cmwc_pkg::CMWC_GOTOSLEEP ##1 mode_reg == cmwc_pkg::CMWC_SLEEP);
  COV_REMOTE_WAKE: cover property (remote_hit && mode_reg == cmwc_pkg::CMWC_SLEEP);
  COV_EXPIRY_SLEEP: cover property (swe_expired ##1 mode_reg == cmwc_pkg::CMWC_SLEEP);
  COV_SWE_EXIT_SILENT: cover property (mode_reg == cmwc_pkg::CMWC_SLEEP && swe_cause_reg ##1
                                       mode_reg == cmwc_pkg::CMWC_SILENT);

endmodule
